// file: logic/data_move_defs.svh
// Purpose: constants for the data transfer instruction decoder
// Assumes: 32-bit operand and address size for immediates and displacements
// Notes:   clock counts are processor clocks before wait states
`ifndef DATA_MOVE_DEFS_SVH
`define DATA_MOVE_DEFS_SVH

// ============================================================
// widths and field positions
`define CNT_W            5
`define TRAIL_W          3
`define W_BIT            0
`define SHORT_W_BIT      3
`define S_BIT            1

// ============================================================
// opcode patterns (upper seven bits unless marked)
`define OPC_COPY_TO_RM   7'h44
`define OPC_COPY_FROM_RM 7'h45
`define OPC_LOAD_ACC     7'h50
`define OPC_STORE_ACC    7'h51
`define OPC_SWAP_RM      7'h43
`define OPC_SEG_LOAD     8'h8e
`define OPC_SEG_STORE    8'h8c
`define OPC_EA_LOAD      8'h8d
`define OPC_ESCAPE       8'h0f
`define OPC_SHORT_IMM    4'hb
`define OPC_SWAP_ACC     5'h12
`define OPC_PUSH_IMM_HI  6'h1a
`define OPC_SIGN_EXT     7'h5f
`define OPC_ZERO_EXT     7'h5b

// ============================================================
// base clock counts
`define CLK_TWO          5'h02
`define CLK_THREE        5'h03
`define CLK_FOUR         5'h04
`define CLK_FIVE         5'h05
`define CLK_SIX          5'h06
`define CLK_SEVEN        5'h07
`define CLK_SEG_PROT_REG 5'h12
`define CLK_SEG_PROT_MEM 5'h13
`define CLK_POP_SEG_PROT 5'h15

// ============================================================
// reset values
`define RST_COUNT        5'h00
`define RST_TRAIL        3'h0
`endif

// file: logic/data_move_pkg.sv
// Purpose: types shared by the data transfer decoder
// Assumes: nothing beyond the constants header
// Notes:   op_kind_t order carries no encoding meaning
package data_move_pkg;

    // ============================================================
    // operation kinds
    typedef enum logic [3:0] {
        K_NONE,
        K_COPY_TO_RM,
        K_COPY_FROM_RM,
        K_COPY_IMM_REG,
        K_LOAD_ACC,
        K_STORE_ACC,
        K_SEG_LOAD,
        K_SEG_STORE,
        K_COPY_SIGN_EXT,
        K_COPY_ZERO_EXT,
        K_PUSH_IMM,
        K_PUSH_SEG,
        K_POP_SEG,
        K_SWAP_RM,
        K_SWAP_ACC,
        K_EA_LOAD
    } op_kind_t;

    // ============================================================
    // decoder states
    typedef enum logic [2:0] {
        S_OPCODE,
        S_ESCAPE,
        S_MODRM,
        S_SIB,
        S_TRAIL,
        S_EXEC
    } state_t;

endpackage : data_move_pkg

// file: logic/data_move_instruction_decode.sv
// Purpose: decode data transfer instructions and time their execution
// Assumes: bytes arrive in order from the prefetch queue on clk_sys
// Notes:   32-bit address size only; two-register addresses need a sib byte
`timescale 1ns/1ns
`include "data_move_defs.svh"

module data_move_instruction_decode
    import data_move_pkg::*;
(
    input  wire logic               clk_sys,       // processor clock
    input  wire logic               reset_n,       // async reset, low
    input  wire logic [7:0]         opcodeByte,    // next instruction byte
    input  wire logic               byteValid,     // byte present
    output logic                    byteReady,     // byte accepted when valid
    input  wire logic               protectedMode, // protected timing
    input  wire logic               dataWait,      // wait state on data access
    output logic                    opValid,       // decode complete pulse
    output op_kind_t                opKind,        // decoded operation
    output logic                    fullWidth,     // width bit
    output logic [1:0]              modField,      // addressing mode
    output logic [2:0]              regField,      // register field
    output logic [2:0]              rmField,       // r/m field
    output logic [2:0]              segField,      // segment register
    output logic                    memOperand,    // operand in memory
    output logic                    twoRegEa,      // two register address
    output logic [`CNT_W-1:0]       clockCount,    // base clocks incl. address
    output logic                    execBusy,      // execution running
    output logic                    execDone,      // execution over pulse
    output logic                    unknownOp      // byte not in this group
);

    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    // ============================================================
    // helper functions
    function automatic logic hasModrm(input op_kind_t k);
        hasModrm = (k == K_COPY_TO_RM) || (k == K_COPY_FROM_RM) ||
                   (k == K_SEG_LOAD) || (k == K_SEG_STORE) ||
                   (k == K_SWAP_RM) || (k == K_EA_LOAD) ||
                   (k == K_COPY_SIGN_EXT) || (k == K_COPY_ZERO_EXT);
    endfunction : hasModrm

    function automatic logic [`TRAIL_W-1:0] dispBytes(input logic [1:0] m,
                                                      input logic [2:0] b);
        dispBytes = (m == 2'h1) ? 3'h1 :
                    (m == 2'h2) ? 3'h4 :
                    (m == 2'h0 && b == 3'h5) ? 3'h4 : 3'h0;
    endfunction : dispBytes

    function automatic logic [`CNT_W-1:0] baseClocks(input op_kind_t k,
                                                     input logic mem,
                                                     input logic prot);
        unique case (k)
            K_COPY_FROM_RM:  baseClocks = mem ? `CLK_FOUR : `CLK_TWO;
            K_LOAD_ACC:      baseClocks = `CLK_FOUR;
            K_SEG_LOAD:      baseClocks = prot ? (mem ? `CLK_SEG_PROT_MEM : `CLK_SEG_PROT_REG)
                                               : (mem ? `CLK_FIVE : `CLK_TWO);
            K_COPY_SIGN_EXT: baseClocks = mem ? `CLK_SIX : `CLK_THREE;
            K_COPY_ZERO_EXT: baseClocks = mem ? `CLK_SIX : `CLK_THREE;
            K_POP_SEG:       baseClocks = prot ? `CLK_POP_SEG_PROT : `CLK_SEVEN;
            K_SWAP_RM:       baseClocks = mem ? `CLK_FIVE : `CLK_THREE;
            K_SWAP_ACC:      baseClocks = `CLK_THREE;
            // copy to r/m, immediates, store, pushes, segment store, ea load
            default:         baseClocks = `CLK_TWO;
        endcase
    endfunction : baseClocks

    // ============================================================
    // state
    state_t                 state, next_state;
    logic [`TRAIL_W-1:0]    trail, next_trail;
    logic [`CNT_W-1:0]      remaining;
    logic                   fire, badOp;

    wire take = byteValid && byteReady;

    // ============================================================
    // first byte decode
    wire [6:0] hi7 = opcodeByte[7:1];
    wire isEscape  = opcodeByte == `OPC_ESCAPE;
    wire isPushSeg = opcodeByte[7:5] == 3'h0 && opcodeByte[2:0] == 3'h6;
    wire isPopSeg  = opcodeByte[7:5] == 3'h0 && opcodeByte[2:0] == 3'h7 &&
                     opcodeByte[4:3] != 2'h1;
    wire isShortImm = opcodeByte[7:4] == `OPC_SHORT_IMM;
    wire isPushImm  = opcodeByte[7:2] == `OPC_PUSH_IMM_HI && !opcodeByte[0];
    wire isSwapAcc  = opcodeByte[7:3] == `OPC_SWAP_ACC;

    wire op_kind_t k1 =
        (hi7 == `OPC_COPY_TO_RM)       ? K_COPY_TO_RM   :
        (hi7 == `OPC_COPY_FROM_RM)     ? K_COPY_FROM_RM :
        isShortImm                     ? K_COPY_IMM_REG :
        (hi7 == `OPC_LOAD_ACC)         ? K_LOAD_ACC     :
        (hi7 == `OPC_STORE_ACC)        ? K_STORE_ACC    :
        (opcodeByte == `OPC_SEG_LOAD)  ? K_SEG_LOAD     :
        (opcodeByte == `OPC_SEG_STORE) ? K_SEG_STORE    :
        isPushImm                      ? K_PUSH_IMM     :
        isPushSeg                      ? K_PUSH_SEG     :
        isPopSeg                       ? K_POP_SEG      :
        (hi7 == `OPC_SWAP_RM)          ? K_SWAP_RM      :
        isSwapAcc                      ? K_SWAP_ACC     :
        (opcodeByte == `OPC_EA_LOAD)   ? K_EA_LOAD      : K_NONE;

    // immediate or displacement bytes that follow a first byte directly
    wire [`TRAIL_W-1:0] trail1 =
        (k1 == K_COPY_IMM_REG) ? (opcodeByte[`SHORT_W_BIT] ? 3'h4 : 3'h1) :
        (k1 == K_LOAD_ACC || k1 == K_STORE_ACC) ? 3'h4 :
        (k1 == K_PUSH_IMM) ? (opcodeByte[`S_BIT] ? 3'h1 : 3'h4) : 3'h0;

    // ============================================================
    // escaped second byte decode
    wire isPushSeg2 = opcodeByte[7:6] == 2'h2 && opcodeByte[2:0] == 3'h0;
    wire isPopSeg2  = opcodeByte[7:6] == 2'h2 && opcodeByte[2:0] == 3'h1;
    wire op_kind_t k2 =
        (hi7 == `OPC_SIGN_EXT) ? K_COPY_SIGN_EXT :
        (hi7 == `OPC_ZERO_EXT) ? K_COPY_ZERO_EXT :
        isPopSeg2              ? K_POP_SEG       :
        isPushSeg2             ? K_PUSH_SEG      : K_NONE;

    // ============================================================
    // mod-reg-r/m and sib fields
    wire [1:0] bMod = opcodeByte[7:6];
    wire [2:0] bReg = opcodeByte[5:3];
    wire [2:0] bRm  = opcodeByte[2:0];
    wire needSib = bMod != 2'h3 && bRm == 3'h4;
    wire [`TRAIL_W-1:0] dispM = dispBytes(bMod, bRm);
    wire [`TRAIL_W-1:0] dispS = dispBytes(modField, bRm);
    // index 100 means none; mod 00 with base 101 drops the base register
    wire sibTwo = bReg != 3'h4 && !(modField == 2'h0 && bRm == 3'h5);

    // ============================================================
    // next state
    always_comb
    begin
        next_state = state;
        next_trail = trail;
        fire       = 1'b0;
        badOp      = 1'b0;
        unique case (state)
            S_OPCODE:
                if (take)
                begin
                    next_trail = trail1;
                    if (isEscape)
                        next_state = S_ESCAPE;
                    else if (k1 == K_NONE)
                        badOp = 1'b1;
                    else if (hasModrm(k1))
                        next_state = S_MODRM;
                    else if (trail1 != 3'h0)
                        next_state = S_TRAIL;
                    else
                        fire = 1'b1;
                end
            S_ESCAPE:
                if (take)
                begin
                    if (k2 == K_NONE)
                    begin
                        badOp      = 1'b1;
                        next_state = S_OPCODE;
                    end
                    else if (hasModrm(k2))
                        next_state = S_MODRM;
                    else
                        fire = 1'b1;
                end
            S_MODRM:
                if (take)
                begin
                    next_trail = dispM;
                    if (needSib)
                        next_state = S_SIB;
                    else if (dispM != 3'h0)
                        next_state = S_TRAIL;
                    else
                        fire = 1'b1;
                end
            S_SIB:
                if (take)
                begin
                    next_trail = dispS;
                    if (dispS != 3'h0)
                        next_state = S_TRAIL;
                    else
                        fire = 1'b1;
                end
            S_TRAIL:
                if (take)
                begin
                    next_trail = trail - 3'h1;
                    if (trail == 3'h1)
                        fire = 1'b1;
                end
            S_EXEC:
                if (!dataWait && remaining == 5'h01)
                    next_state = S_OPCODE;
        endcase
        if (fire)
            next_state = S_EXEC;
    end

    // ============================================================
    // field capture
    wire atOpc = state == S_OPCODE && take;
    wire atEsc = state == S_ESCAPE && take;
    wire atMod = state == S_MODRM && take;
    wire atSib = state == S_SIB && take;

    wire op_kind_t next_kind = atOpc ? k1 : atEsc ? k2 : opKind;
    wire next_mem = atOpc ? (k1 == K_LOAD_ACC || k1 == K_STORE_ACC) :
                    atMod ? (bMod != 2'h3) : memOperand;
    wire next_two = atOpc ? 1'b0 : atSib ? sibTwo : twoRegEa;
    wire [`CNT_W-1:0] next_count = baseClocks(next_kind, next_mem, protectedMode) +
                                   {{(`CNT_W-1){1'b0}}, next_two};
    // width bit: clear is byte, set is full; forms without one are full
    wire next_width = atOpc ? (isShortImm ? opcodeByte[`SHORT_W_BIT] :
                               (hasModrm(k1) && k1 != K_SEG_LOAD && k1 != K_SEG_STORE &&
                                k1 != K_EA_LOAD) || k1 == K_LOAD_ACC ||
                               k1 == K_STORE_ACC ? opcodeByte[`W_BIT] : 1'b1) :
                      atEsc ? (hasModrm(k2) ? opcodeByte[`W_BIT] : 1'b1) :
                      fullWidth;
    wire [2:0] next_seg = atOpc ? {1'b0, opcodeByte[4:3]} :
                          atEsc ? bReg :
                          (atMod && (opKind == K_SEG_LOAD || opKind == K_SEG_STORE))
                              ? bReg : segField;
    wire [2:0] next_reg = atOpc ? ((isShortImm || isSwapAcc) ? bRm : 3'h0) :
                          atMod ? bReg : regField;

    // ============================================================
    // registers
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state      <= S_OPCODE;
            trail      <= `RST_TRAIL;
            remaining  <= `RST_COUNT;
            clockCount <= `RST_COUNT;
            byteReady  <= 1'b1;
            opValid    <= 1'b0;
            opKind     <= K_NONE;
            fullWidth  <= 1'b0;
            modField   <= 2'h0;
            regField   <= 3'h0;
            rmField    <= 3'h0;
            segField   <= 3'h0;
            memOperand <= 1'b0;
            twoRegEa   <= 1'b0;
            execBusy   <= 1'b0;
            execDone   <= 1'b0;
            unknownOp  <= 1'b0;
        end
        else
        begin
            state      <= next_state;
            trail      <= next_trail;
            byteReady  <= next_state != S_EXEC;
            execBusy   <= next_state == S_EXEC;
            opValid    <= fire;
            unknownOp  <= badOp;
            execDone   <= state == S_EXEC && !dataWait && remaining == 5'h01;
            opKind     <= next_kind;
            memOperand <= next_mem;
            twoRegEa   <= next_two;
            fullWidth  <= next_width;
            segField   <= next_seg;
            regField   <= next_reg;
            if (atMod)
            begin
                modField <= bMod;
                rmField  <= bRm;
            end
            if (fire)
            begin
                clockCount <= next_count;
                remaining  <= next_count;
            end
            else if (state == S_EXEC && !dataWait)
                remaining <= remaining - 5'h01;
        end
    end

    // ============================================================
    // checks
    a_copy_to_rm: assert property (opValid && opKind == K_COPY_TO_RM |->
        clockCount == 5'h02 + twoRegEa) else $error("copy to r/m count wrong");
    a_copy_from_rm: assert property (opValid && opKind == K_COPY_FROM_RM |->
        clockCount == (memOperand ? 5'h04 + twoRegEa : 5'h02)) else $error("load count wrong");
    a_short_forms: assert property (opValid && (opKind == K_COPY_IMM_REG ||
        opKind == K_STORE_ACC || opKind == K_PUSH_IMM || opKind == K_PUSH_SEG) |->
        clockCount == 5'h02) else $error("two clock form count wrong");
    a_acc_load: assert property (opValid && opKind == K_LOAD_ACC |->
        clockCount == 5'h04 && memOperand) else $error("accumulator load count wrong");
    a_seg_load: assert property (opValid && opKind == K_SEG_LOAD && !memOperand |->
        clockCount == ($past(protectedMode) ? 5'h12 : 5'h02)) else $error("seg load count wrong");
    a_pop_seg: assert property (opValid && opKind == K_POP_SEG |->
        clockCount == ($past(protectedMode) ? 5'h15 : 5'h07)) else $error("pop count wrong");
    a_extend_copy: assert property (opValid && (opKind == K_COPY_SIGN_EXT ||
        opKind == K_COPY_ZERO_EXT) |-> clockCount == (memOperand ? 5'h06 + twoRegEa : 5'h03))
        else $error("extending copy count wrong");
    a_swap_counts: assert property (opValid && (opKind == K_SWAP_RM ||
        opKind == K_SWAP_ACC) |-> clockCount == ((opKind == K_SWAP_RM && memOperand) ?
        5'h05 + twoRegEa : 5'h03)) else $error("swap count wrong");
    a_ea_load: assert property (opValid && opKind == K_EA_LOAD |->
        clockCount == 5'h02 + twoRegEa) else $error("address load count wrong");
    a_two_clock_run: assert property (opValid && clockCount == 5'h02 && !dataWait
        ##1 !dataWait |=> execDone ##1 !execBusy) else $error("two clock run length wrong");
    a_wait_stretch: assert property (opValid && clockCount == 5'h02 && dataWait
        ##1 !dataWait ##1 !dataWait |-> !execDone ##1 execDone) else $error("wait not added");
    a_ready_gated: assert property (execBusy |-> !byteReady)
        else $error("byte taken during execution");

endmodule : data_move_instruction_decode

// file: tb/fetch_exec_model.sv
// Purpose: prefetch queue and execution stage facing the decoder
// Assumes: a byte stays offered until the decoder takes it
// Notes:   an empty queue toggles the offered byte each clock between the last byte and its inverse
`timescale 1ns/1ns

module fetch_exec_model
(
    input  wire logic       clk_sys,    // processor clock
    input  wire logic       byteReady,  // decoder takes a byte
    input  wire logic       execBusy,   // execution window
    output logic [7:0]      opcodeByte, // byte offered
    output logic            byteValid,  // byte present
    output logic            dataWait    // wait state on data access
);
    logic [7:0] fifo[$];
    int         waitLeft = 0;
    logic       taken;

    // ============================================================
    // stimulus hooks
    task automatic push(input logic [7:0] b);
        fifo.push_back(b);
    endtask : push

    task automatic set_waits(input int n);
        waitLeft = n;
    endtask : set_waits

    // ============================================================
    // byte offer and wait states, changed just after each edge
    initial
    begin
        opcodeByte = 8'h00;
        byteValid = 1'b0;
        dataWait = 1'b0;
    end

    always @(posedge clk_sys)
    begin
        taken = byteValid && byteReady;
        #1;
        if (taken)
            void'(fifo.pop_front());
        byteValid = (fifo.size() > 0);
        opcodeByte = byteValid ? fifo[0] : ~opcodeByte;
        // waits only inside the busy window, where the decoder counts them
        dataWait = execBusy && (waitLeft > 0);
        if (dataWait)
            waitLeft--;
    end
endmodule : fetch_exec_model

// file: tb/data_move_instruction_decode_tb_top.sv
// Purpose: self-checking bench for the data transfer decoder
// Assumes: no prefix bytes, 32-bit addressing
// Notes:   each do_op waits for opValid and execDone under a bound
`timescale 1ns/1ns

module data_move_instruction_decode_tb_top;
    import data_move_pkg::*;

    logic       clk_sys, reset_n, protectedMode, byteReady, byteValid, dataWait;
    logic       opValid, fullWidth, memOperand, twoRegEa, execBusy, execDone;
    logic       unknownOp;
    logic [7:0] opcodeByte;
    logic [1:0] modField;
    logic [2:0] regField, rmField, segField;
    logic [4:0] clockCount;
    op_kind_t   opKind;
    int         errorCnt = 0;
    int         compares = 0;

    // ============================================================
    // instances
    data_move_instruction_decode data_move_instruction_decode_i (.clk_sys(clk_sys),
        .reset_n(reset_n), .opcodeByte(opcodeByte), .byteValid(byteValid),
        .byteReady(byteReady), .protectedMode(protectedMode), .dataWait(dataWait),
        .opValid(opValid), .opKind(opKind), .fullWidth(fullWidth), .modField(modField),
        .regField(regField), .rmField(rmField), .segField(segField),
        .memOperand(memOperand), .twoRegEa(twoRegEa), .clockCount(clockCount),
        .execBusy(execBusy), .execDone(execDone), .unknownOp(unknownOp));
    fetch_exec_model fetch_exec_model_i (.clk_sys(clk_sys), .byteReady(byteReady),
        .execBusy(execBusy), .opcodeByte(opcodeByte), .byteValid(byteValid),
        .dataWait(dataWait));

    // ============================================================
    // checking helpers
    task automatic report_and_stop;
        $display("errors %0d compares %0d", errorCnt, compares);
        if (errorCnt == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop

    task automatic chk_num(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            errorCnt++;
            $display("BAD %0t value %h want %h", $time, got, exp);
        end
    endtask : chk_num

    task automatic chk_kind(input op_kind_t got, input op_kind_t exp);
        compares++;
        if (got !== exp)
        begin
            errorCnt++;
            $display("BAD %0t kind %s want %s", $time, got.name(), exp.name());
        end
    endtask : chk_kind

    task automatic tick(inout int i);
        @(posedge clk_sys);
        #1;
        i++;
        if (i > 80)
        begin
            errorCnt++;
            $display("BAD %0t no handshake", $time);
            report_and_stop();
        end
    endtask : tick

    // bytes right-aligned; mem of x skips the operand check
    task automatic do_op(input logic [39:0] bytes, input int n, input logic prot,
                         input int waits, input op_kind_t k, input logic [7:0] cnt,
                         input logic mem);
        int i;
        @(posedge clk_sys);
        #1;
        protectedMode = prot;
        fetch_exec_model_i.set_waits(waits);
        for (i = n; i > 0; i--)
            fetch_exec_model_i.push(bytes[8*i-1 -: 8]);
        i = 0;
        while (opValid !== 1'b1)
            tick(i);
        chk_kind(opKind, k);
        chk_num(8'(clockCount), cnt);
        if (mem !== 1'bx)
            chk_num(8'(memOperand), 8'(mem));
        i = 0;
        while (execDone !== 1'b1)
            tick(i);
        chk_num(8'(i), cnt + 8'(waits));
    endtask : do_op

    // ============================================================
    // scenarios
    task automatic sc_copy;
        do_op(40'h89c0, 2, 1'b0, 0, K_COPY_TO_RM, 8'h02, 1'b0);
        do_op(40'h8803, 2, 1'b1, 0, K_COPY_TO_RM, 8'h02, 1'b1);
        chk_num(8'(fullWidth), 8'h00);
        do_op(40'h8bc0, 2, 1'b0, 0, K_COPY_FROM_RM, 8'h02, 1'b0);
        do_op(40'h8b00, 2, 1'b0, 0, K_COPY_FROM_RM, 8'h04, 1'b1);
        chk_num(8'(fullWidth), 8'h01);
    endtask : sc_copy

    task automatic sc_immediate;
        do_op(40'hbb11223344, 5, 1'b0, 0, K_COPY_IMM_REG, 8'h02, 1'bx);
        chk_num(8'(regField), 8'h03);
        do_op(40'hb155, 2, 1'b0, 0, K_COPY_IMM_REG, 8'h02, 1'bx);
        chk_num(8'(fullWidth), 8'h00);
        do_op(40'h6811223344, 5, 1'b0, 0, K_PUSH_IMM, 8'h02, 1'bx);
        do_op(40'h6a7f, 2, 1'b1, 0, K_PUSH_IMM, 8'h02, 1'bx);
    endtask : sc_immediate

    task automatic sc_accumulator;
        do_op(40'ha100001000, 5, 1'b0, 0, K_LOAD_ACC, 8'h04, 1'b1);
        do_op(40'ha300001000, 5, 1'b1, 0, K_STORE_ACC, 8'h02, 1'b1);
    endtask : sc_accumulator

    task automatic sc_segment;
        do_op(40'h8ed8, 2, 1'b0, 0, K_SEG_LOAD, 8'h02, 1'b0);
        do_op(40'h8e18, 2, 1'b0, 0, K_SEG_LOAD, 8'h05, 1'b1);
        chk_num(8'(segField), 8'h03);
        do_op(40'h8ed8, 2, 1'b1, 0, K_SEG_LOAD, 8'h12, 1'b0);
        do_op(40'h8e18, 2, 1'b1, 0, K_SEG_LOAD, 8'h13, 1'b1);
        do_op(40'h8c18, 2, 1'b1, 0, K_SEG_STORE, 8'h02, 1'b1);
    endtask : sc_segment

    task automatic sc_extend;
        do_op(40'h0fbfc0, 3, 1'b0, 0, K_COPY_SIGN_EXT, 8'h03, 1'b0);
        do_op(40'h0fbe00, 3, 1'b0, 0, K_COPY_SIGN_EXT, 8'h06, 1'b1);
        do_op(40'h0fb700, 3, 1'b1, 0, K_COPY_ZERO_EXT, 8'h06, 1'b1);
    endtask : sc_extend

    task automatic sc_stack;
        do_op(40'h06, 1, 1'b1, 0, K_PUSH_SEG, 8'h02, 1'bx);
        do_op(40'h1f, 1, 1'b0, 0, K_POP_SEG, 8'h07, 1'bx);
        do_op(40'h1f, 1, 1'b1, 0, K_POP_SEG, 8'h15, 1'bx);
        do_op(40'h0fa9, 2, 1'b0, 0, K_POP_SEG, 8'h07, 1'bx);
        chk_num(8'(segField), 8'h05);
        do_op(40'h0fa9, 2, 1'b1, 0, K_POP_SEG, 8'h15, 1'bx);
        do_op(40'h0fa0, 2, 1'b1, 0, K_PUSH_SEG, 8'h02, 1'bx);
        chk_num(8'(segField), 8'h04);
    endtask : sc_stack

    task automatic sc_swap;
        do_op(40'h87c0, 2, 1'b0, 0, K_SWAP_RM, 8'h03, 1'b0);
        do_op(40'h8700, 2, 1'b0, 0, K_SWAP_RM, 8'h05, 1'b1);
        do_op(40'h93, 1, 1'b1, 0, K_SWAP_ACC, 8'h03, 1'bx);
        chk_num(8'(regField), 8'h03);
        do_op(40'h8d00, 2, 1'b0, 0, K_EA_LOAD, 8'h02, 1'b1);
    endtask : sc_swap

    task automatic sc_fields;
        do_op(40'h8b5a10, 3, 1'b0, 0, K_COPY_FROM_RM, 8'h04, 1'b1);
        chk_num({modField, regField, rmField}, 8'h5a);
        do_op(40'h8b0418, 3, 1'b0, 0, K_COPY_FROM_RM, 8'h05, 1'b1);
        chk_num(8'(twoRegEa), 8'h01);
        do_op(40'h8900, 2, 1'b0, 3, K_COPY_TO_RM, 8'h02, 1'b1);
        do_op(40'h89c0, 2, 1'b0, 1, K_COPY_TO_RM, 8'h02, 1'b0);
    endtask : sc_fields

    // dropped bytes, then a reset in mid-execution with the queue already empty
    task automatic sc_recover;
        int i;
        @(posedge clk_sys);
        #1;
        fetch_exec_model_i.push(8'hf8);
        fetch_exec_model_i.push(8'h0f);
        fetch_exec_model_i.push(8'h05);
        i = 0;
        while (unknownOp !== 1'b1)
            tick(i);
        chk_kind(opKind, K_NONE);
        tick(i);
        while (unknownOp !== 1'b1)
            tick(i);
        chk_kind(opKind, K_NONE);
        do_op(40'h89c0, 2, 1'b0, 0, K_COPY_TO_RM, 8'h02, 1'b0);
        protectedMode = 1'b1;
        fetch_exec_model_i.push(8'h1f);
        i = 0;
        while (opValid !== 1'b1)
            tick(i);
        reset_n = 1'b0;
        @(posedge clk_sys);
        #1;
        reset_n = 1'b1;
        chk_num(8'(execBusy), 8'h00);
        chk_num(8'(byteReady), 8'h01);
        do_op(40'h1f, 1, 1'b0, 0, K_POP_SEG, 8'h07, 1'bx);
    endtask : sc_recover

    // ============================================================
    // clock, reset and sequence
    initial
    begin
        clk_sys = 1'b0;
        forever
            #25 clk_sys = ~clk_sys;
    end

    initial
    begin
        reset_n = 1'b0;
        protectedMode = 1'b0;
        repeat (6) @(posedge clk_sys);
        #1;
        reset_n = 1'b1;
        sc_copy();
        sc_immediate();
        sc_accumulator();
        sc_segment();
        sc_extend();
        sc_stack();
        sc_swap();
        sc_fields();
        sc_recover();
        report_and_stop();
    end
endmodule : data_move_instruction_decode_tb_top
